// ==== pwc_pkg.sv ====
package pwc_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_IRQ_ENABLE_SET = 12'h304;
    localparam logic [11:0] OFS_IRQ_ENABLE_CLEAR = 12'h308;
    localparam logic [11:0] OFS_MODULE_ENABLE = 12'h500;
    localparam logic [11:0] OFS_COUNT_DIRECTION_MODE = 12'h504;
    localparam logic [11:0] OFS_WAVE_PERIOD_MAX = 12'h508;
    localparam logic [11:0] OFS_DECODER_LOAD = 12'h510;
    localparam logic [11:0] OFS_EVENT_STATUS = 12'h104;

    // event bit positions
    localparam int EV_LO = 1;
    localparam int EV_HI = 7;
    localparam int EV_HALT = 1;
    localparam int EV_SEQ_BEGUN0 = 2;
    localparam int EV_SEQ_FINISH0 = 4;
    localparam int EV_PERIOD = 6;
    localparam int EV_LOOPS = 7;

    // top reset value, ram load code, minimum top
    localparam logic [14:0] RST_WAVE_PERIOD_MAX = 15'h03FF;
    localparam logic [1:0] LOAD_PERIOD_FROM_RAM = 2'h3;
    localparam logic [14:0] TOP_MIN = 15'h0003;

    typedef enum logic [1:0] {
        PWC_ST_UP = 2'h0,
        PWC_ST_DOWN = 2'h1,
        PWC_ST_IDLE = 2'h2
    } pwc_state_t;

    typedef struct packed {
        logic halt_done_event;
        logic [1:0] sequence_begun_event;
        logic [1:0] sequence_finish_event;
        logic period_finish_event;
        logic all_loops_finished_event;
    } pwc_events_t;

endpackage

// ==== pwc_top.sv ====
// Notes on behaviour
// [RULE_01] write one at 0x304 sets enable
// [RULE_02] write one at 0x308 clears enable
// [RULE_03] both views read same enable state
// [RULE_04] seven event enable bits exist
// [RULE_05] direction zero: up count, edge aligned
// [RULE_06] direction one: up-down, center aligned
// [RULE_07] top register holds count limit
// [RULE_08] ram load mode ignores top register
// [RULE_09] fourth half-word supplies top value
// [RULE_10] writing zero leaves enable unchanged
// [RULE_11] irq while enabled event flag set
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module pwc_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire pwc_pkg::pwc_events_t events_i,
    input wire logic ram_top_valid_i,
    input wire logic [15:0] ram_top_i,
    output logic irq_o,
    output logic [14:0] counter_o,
    output logic count_down_o,
    output logic period_end_o
);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire logic acc = psel_i && penable_i;
    wire logic wr = acc && pwrite_i;
    wire logic rd = acc && !pwrite_i;
    wire logic hit_set = paddr_i == pwc_pkg::OFS_IRQ_ENABLE_SET;
    wire logic hit_clr = paddr_i == pwc_pkg::OFS_IRQ_ENABLE_CLEAR;
    wire logic hit_en = paddr_i == pwc_pkg::OFS_MODULE_ENABLE;
    wire logic hit_mode = paddr_i == pwc_pkg::OFS_COUNT_DIRECTION_MODE;
    wire logic hit_top = paddr_i == pwc_pkg::OFS_WAVE_PERIOD_MAX;
    wire logic hit_dec = paddr_i == pwc_pkg::OFS_DECODER_LOAD;
    wire logic hit_stat = paddr_i == pwc_pkg::OFS_EVENT_STATUS;
    wire logic mapped = hit_set || hit_clr || hit_en || hit_mode || hit_top || hit_dec
        || hit_stat;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] irq_enable_reg;
    logic [7:0] irq_enable_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic module_enable_reg;
    logic count_direction_reg;
    logic [14:0] wave_period_max_reg;
    logic [1:0] decoder_load_reg;
    logic [14:0] ram_top_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic count_down_reg;

    wire logic [7:0] ev_vec = {events_i.all_loops_finished_event, events_i.period_finish_event,
        events_i.sequence_finish_event[1], events_i.sequence_finish_event[0],
        events_i.sequence_begun_event[1], events_i.sequence_begun_event[0],
        events_i.halt_done_event, 1'b0};
    wire logic [7:0] ev_mask = 8'hFE;
    wire logic [7:0] wmask = pwdata_i[7:0] & ev_mask;
    wire logic [7:0] ev_live = ev_vec & ev_mask;

    // set after clear so a same-cycle event still lands
    wire logic stat_rd = rd && hit_stat && !pready_reg;

    generate
        for (genvar i = 0; i < 8; i++) begin : g_bit
            always_comb begin
                irq_enable_next[i] = irq_enable_reg[i];
                if (wr && !pready_reg && hit_set && wmask[i]) begin
                    irq_enable_next[i] = 1'b1; // [RULE_01] [RULE_10]
                end
                if (wr && !pready_reg && hit_clr && wmask[i]) begin
                    irq_enable_next[i] = 1'b0; // [RULE_02] [RULE_10]
                end
                status_next[i] = (stat_rd ? 1'b0 : status_reg[i]) | ev_vec[i];
            end
        end
    endgenerate

    // both views return the same enable image
    wire logic [31:0] rd_mux = (hit_set || hit_clr) ? {24'h0, irq_enable_reg} : // [RULE_03]
        hit_en ? {31'h0, module_enable_reg} :
        hit_mode ? {31'h0, count_direction_reg} :
        hit_top ? {17'h0, wave_period_max_reg} :
        hit_dec ? {30'h0, decoder_load_reg} :
        hit_stat ? {24'h0, status_reg} : 32'h0;

    wire logic irq_next = |(status_next & irq_enable_next & ev_mask); // [RULE_11] [RULE_04]

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_enable_reg <= 8'h00;
            status_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            irq_enable_reg <= irq_enable_next & ev_mask; // [RULE_04]
            status_reg <= status_next & ev_mask;
            irq_reg <= irq_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            module_enable_reg <= 1'b0;
            count_direction_reg <= 1'b0;
            wave_period_max_reg <= pwc_pkg::RST_WAVE_PERIOD_MAX; // [RULE_07]
            decoder_load_reg <= 2'h0;
        end else if (wr && !pready_reg) begin
            if (hit_en) begin
                module_enable_reg <= pwdata_i[0];
            end
            if (hit_mode) begin
                count_direction_reg <= pwdata_i[0];
            end
            if (hit_top) begin
                wave_period_max_reg <= pwdata_i[14:0]; // [RULE_07]
            end
            if (hit_dec) begin
                decoder_load_reg <= pwdata_i[1:0];
            end
        end
    end

    // one wait state: answer on second access cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= acc && !pready_reg;
            pslverr_reg <= acc && !pready_reg && !mapped;
            prdata_reg <= (rd && !pready_reg) ? rd_mux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ram-fed top value
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ram_top_reg <= pwc_pkg::RST_WAVE_PERIOD_MAX;
        end else if (ram_top_valid_i) begin
            ram_top_reg <= ram_top_i[14:0]; // [RULE_09]
        end
    end

    wire logic ram_mode = decoder_load_reg == pwc_pkg::LOAD_PERIOD_FROM_RAM;
    wire logic [14:0] top_raw = ram_mode ? ram_top_reg : wave_period_max_reg; // [RULE_08]
    wire logic [14:0] top_eff = (top_raw < pwc_pkg::TOP_MIN) ? pwc_pkg::TOP_MIN : top_raw;

    ////////////////////////////////////////////////////////////////////////////
    // wave counter
    pwc_pkg::pwc_state_t state_reg;
    pwc_pkg::pwc_state_t state_next;
    logic [14:0] cnt_reg;
    logic [14:0] cnt_next;
    logic pend_reg;
    logic pend_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        pend_next = 1'b0;
        case (state_reg)
            pwc_pkg::PWC_ST_IDLE: begin
                cnt_next = 15'h0;
                if (module_enable_reg) begin
                    state_next = pwc_pkg::PWC_ST_UP;
                end
            end
            pwc_pkg::PWC_ST_UP: begin
                if (cnt_reg + 15'h1 < top_eff) begin
                    cnt_next = cnt_reg + 15'h1;
                end else if (count_direction_reg) begin
                    cnt_next = top_eff; // [RULE_06]
                    state_next = pwc_pkg::PWC_ST_DOWN;
                end else begin
                    cnt_next = 15'h0; // [RULE_05]
                    pend_next = 1'b1;
                end
            end
            pwc_pkg::PWC_ST_DOWN: begin
                if (!count_direction_reg) begin
                    cnt_next = 15'h0; // [RULE_05]
                    pend_next = 1'b1;
                    state_next = pwc_pkg::PWC_ST_UP;
                end else if (cnt_reg > 15'h1) begin
                    cnt_next = cnt_reg - 15'h1; // [RULE_06]
                end else begin
                    cnt_next = 15'h0;
                    pend_next = 1'b1;
                    state_next = pwc_pkg::PWC_ST_UP;
                end
            end
            default: begin
                state_next = pwc_pkg::PWC_ST_IDLE;
            end
        endcase
        if (!module_enable_reg) begin
            state_next = pwc_pkg::PWC_ST_IDLE;
            cnt_next = 15'h0;
            pend_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= pwc_pkg::PWC_ST_IDLE;
            cnt_reg <= 15'h0;
            pend_reg <= 1'b0;
            count_down_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pend_reg <= pend_next;
            count_down_reg <= state_next == pwc_pkg::PWC_ST_DOWN; // [RULE_06]
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign irq_o = irq_reg;
    assign counter_o = cnt_reg;
    assign count_down_o = count_down_reg;
    assign period_end_o = pend_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_set_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr && !pready_reg && hit_set) |=> (irq_enable_reg & $past(wmask)) == $past(wmask);
    endproperty
    a_set_write: assert property (p_set_write) else $error("set write lost"); // [RULE_01]

    property p_clr_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr && !pready_reg && hit_clr) |=> (irq_enable_reg & $past(wmask)) == 8'h00;
    endproperty
    a_clr_write: assert property (p_clr_write) else $error("clear write lost"); // [RULE_02]

    property p_zero_keep;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr && (hit_set || hit_clr) && pwdata_i[7:0] == 8'h00) |=> $stable(irq_enable_reg);
    endproperty
    a_zero_keep: assert property (p_zero_keep) else $error("zero write changed enable"); // [RULE_10]

    property p_same_view;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd && !pready_reg && (hit_set || hit_clr)) |=> prdata_o[7:0] == $past(irq_enable_reg);
    endproperty
    a_same_view: assert property (p_same_view) else $error("enable readback wrong"); // [RULE_03]

    property p_bit0_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        !irq_enable_reg[0] && !status_reg[0];
    endproperty
    a_bit0_zero: assert property (p_bit0_zero) else $error("unused bit set"); // [RULE_04]

    property p_irq_level;
        @(posedge clk_i) disable iff (!rst_n_i)
        ##1 irq_o == |(status_reg & irq_enable_reg);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq mismatch"); // [RULE_11]

    property p_up_only;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!count_direction_reg && module_enable_reg) |-> state_reg != pwc_pkg::PWC_ST_DOWN
            || $past(count_direction_reg);
    endproperty
    a_up_only: assert property (p_up_only) else $error("down count in up mode"); // [RULE_05]

    property p_turn;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == pwc_pkg::PWC_ST_UP && count_direction_reg && module_enable_reg
            && cnt_reg + 15'h1 >= top_eff) |=> (state_reg == pwc_pkg::PWC_ST_DOWN
            || !module_enable_reg);
    endproperty
    a_turn: assert property (p_turn) else $error("no turn at top"); // [RULE_06]

    property p_top_limit;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == pwc_pkg::PWC_ST_UP && !count_direction_reg) |-> cnt_reg < top_eff
            || $changed(top_eff);
    endproperty
    a_top_limit: assert property (p_top_limit) else $error("count above top"); // [RULE_07]

    property p_ram_top;
        @(posedge clk_i) disable iff (!rst_n_i)
        ram_mode |-> top_raw == ram_top_reg;
    endproperty
    a_ram_top: assert property (p_ram_top) else $error("top register used in ram mode"); // [RULE_08]

    property p_ram_load;
        @(posedge clk_i) disable iff (!rst_n_i)
        ram_top_valid_i |=> ram_top_reg == $past(ram_top_i[14:0]);
    endproperty
    a_ram_load: assert property (p_ram_load) else $error("fourth half-word not taken"); // [RULE_09]

    property p_status_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        (|ev_live) |=> (status_reg & $past(ev_live)) == $past(ev_live);
    endproperty
    a_status_set: assert property (p_status_set) else $error("event flag lost"); // [RULE_11]

    property p_period_wrap;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == pwc_pkg::PWC_ST_UP && !count_direction_reg && module_enable_reg
            && cnt_reg + 15'h1 >= top_eff) |=> (counter_o == 15'h0 && period_end_o);
    endproperty
    a_period_wrap: assert property (p_period_wrap) else $error("no wrap at top"); // [RULE_05]

    property p_down_step;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == pwc_pkg::PWC_ST_DOWN && count_direction_reg && module_enable_reg
            && cnt_reg > 15'h1) |=> counter_o == $past(cnt_reg) - 15'h1;
    endproperty
    a_down_step: assert property (p_down_step) else $error("down step wrong"); // [RULE_06]

    property p_top_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr && !pready_reg && hit_top) |=> wave_period_max_reg == $past(pwdata_i[14:0]);
    endproperty
    a_top_write: assert property (p_top_write) else $error("top write lost"); // [RULE_07]

    property p_mode_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr && !pready_reg && hit_mode) |=> count_direction_reg == $past(pwdata_i[0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // [RULE_05]

endmodule

// ==== pwm_irq_enable_and_counter_cfg_tb.sv ====
`timescale 1ns/10ps
module pwm_irq_enable_and_counter_cfg_tb;
    localparam logic [11:0] A_SET = pwc_pkg::OFS_IRQ_ENABLE_SET;
    localparam logic [11:0] A_CLR = pwc_pkg::OFS_IRQ_ENABLE_CLEAR;
    localparam logic [11:0] A_DIR = pwc_pkg::OFS_COUNT_DIRECTION_MODE;
    localparam logic [11:0] A_TOP = pwc_pkg::OFS_WAVE_PERIOD_MAX;
    localparam logic [11:0] A_STS = pwc_pkg::OFS_EVENT_STATUS;
    localparam logic [11:0] A_EN = pwc_pkg::OFS_MODULE_ENABLE;
    localparam logic [11:0] A_LD = pwc_pkg::OFS_DECODER_LOAD;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    pwc_pkg::pwc_events_t events_i = '0;
    logic ram_top_valid_i = 1'b0;
    logic [15:0] ram_top_i = 16'h0;
    logic irq_o;
    logic [14:0] counter_o;
    logic count_down_o;
    logic period_end_o;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;
    logic [14:0] mx;
    logic dn;
    int np;
    logic pb;
    typedef struct {
        logic wr;
        logic [11:0] addr;
        logic [31:0] data;
        logic err;
    } pwc_row_t;
    pwc_row_t rows [0:21] = '{
        '{1'b0, A_SET, 32'h0, 1'b0}, '{1'b0, A_CLR, 32'h0, 1'b0},
        '{1'b0, A_DIR, 32'h0, 1'b0}, '{1'b0, A_TOP, 32'h3FF, 1'b0},
        '{1'b0, A_STS, 32'h0, 1'b0}, '{1'b1, A_SET, 32'hFFFFFFFF, 1'b0},
        '{1'b0, A_SET, 32'hFE, 1'b0}, '{1'b0, A_CLR, 32'hFE, 1'b0},
        '{1'b1, A_SET, 32'h0, 1'b0}, '{1'b1, A_CLR, 32'h0, 1'b0},
        '{1'b0, A_CLR, 32'hFE, 1'b0}, '{1'b1, A_CLR, 32'h14, 1'b0},
        '{1'b0, A_SET, 32'hEA, 1'b0}, '{1'b1, A_CLR, 32'hEA, 1'b0},
        '{1'b0, A_SET, 32'h0, 1'b0}, '{1'b0, 12'h000, 32'h0, 1'b1},
        '{1'b1, 12'h00C, 32'h5A, 1'b1}, '{1'b1, A_TOP, 32'h7FFF, 1'b0},
        '{1'b0, A_TOP, 32'h7FFF, 1'b0}, '{1'b1, A_DIR, 32'h1, 1'b0},
        '{1'b0, A_DIR, 32'h1, 1'b0}, '{1'b1, A_DIR, 32'h0, 1'b0}
    };

    pwc_top pwc_top_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .events_i(events_i),
        .ram_top_valid_i(ram_top_valid_i),
        .ram_top_i(ram_top_i),
        .irq_o(irq_o),
        .counter_o(counter_o),
        .count_down_o(count_down_o),
        .period_end_o(period_end_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always #20 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("mismatches %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic c, input string msg);
        n_tests++;
        if (!c) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk_i);
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        check(k < 20, "apb answer missing");
        @(posedge clk_i);
    endtask

    task automatic pulse(input pwc_pkg::pwc_events_t e);
        events_i <= e;
        @(posedge clk_i);
        events_i <= '0;
        repeat (3) @(posedge clk_i);
    endtask

    // largest counter value and any down count over n cycles
    task automatic watch(input int n);
        mx = 15'h0;
        dn = 1'b0;
        np = 0;
        pb = 1'b0;
        repeat (n) begin
            @(posedge clk_i);
            if (counter_o > mx) mx = counter_o;
            if (count_down_o === 1'b1) dn = 1'b1;
            if (period_end_o === 1'b1) np++;
            if (period_end_o === 1'b1 && counter_o !== 15'h0) pb = 1'b1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 22; i++) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            check(er === rows[i].err, "slave error");
            if (rows[i].wr == 1'b0) begin
                check(rd === rows[i].data, "read data");
            end
        end
        // masked event, then enabled event, then enable cleared
        apb(1'b1, A_SET, 32'h40);
        pulse('{1'b1, 2'h0, 2'h0, 1'b0, 1'b0});
        check(irq_o === 1'b0, "masked irq");
        apb(1'b0, A_STS, 32'h0);
        check(rd === 32'h2, "status halt");
        pulse('{1'b0, 2'h0, 2'h0, 1'b1, 1'b0});
        check(irq_o === 1'b1, "irq high");
        apb(1'b1, A_CLR, 32'h40);
        repeat (2) @(posedge clk_i);
        check(irq_o === 1'b0, "irq after clear");
        apb(1'b0, A_STS, 32'h0);
        check(rd === 32'h40, "status period");
        // wave counter
        apb(1'b1, A_TOP, 32'h5);
        apb(1'b1, A_EN, 32'h1);
        watch(30);
        check(mx === 15'h4 && dn === 1'b0, "up count");
        check(np >= 5 && pb === 1'b0, "period end up");
        apb(1'b1, A_LD, 32'h3);
        ram_top_i <= 16'h0007;
        ram_top_valid_i <= 1'b1;
        @(posedge clk_i);
        ram_top_valid_i <= 1'b0;
        watch(10);
        watch(40);
        check(mx === 15'h6, "ram top");
        apb(1'b1, A_LD, 32'h0);
        watch(10);
        watch(30);
        check(mx === 15'h4, "register top");
        apb(1'b1, A_DIR, 32'h1);
        watch(10);
        watch(30);
        check(mx === 15'h5 && dn === 1'b1, "up down count");
        check(np >= 2 && pb === 1'b0, "period end up down");
        // reset in mid-run
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        check(counter_o === 15'h0 && irq_o === 1'b0 && count_down_o === 1'b0, "reset outputs");
        apb(1'b0, A_TOP, 32'h0);
        check(rd === 32'h3FF, "top after reset");
        apb(1'b0, A_DIR, 32'h0);
        check(rd === 32'h0, "mode after reset");
        print_verdict();
    end
endmodule
